// ===== hw/ccst_top.sv
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ccst_cfg.svh"

module ccst_top import ccst_pkg::*; #(
    parameter int ONESHOT_CYC = `CCST_ONESHOT_CYC,
    parameter int SCAN_MIN_CYC = `CCST_SCAN_MIN_CYC,
    parameter int SCAN_MAX_CYC = `CCST_SCAN_MAX_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [4:0] svc_sw_i,
    input wire logic [7:0] cfg_sw_i,
    output logic oneshot_o,
    output logic tick_o,
    output logic [4:0] scan_item_o,
    output logic timer_fault_o,
    output logic hw_tick_o,
    output logic proc_reset_o,
    output logic test_irq_o,
    output logic kernel_test_o,
    output logic frozen_o,
    output ccst_cfg_t cfg_o
);
    localparam logic [16:0] OS_LOAD = 17'(ONESHOT_CYC - 1);
    localparam logic [20:0] SCAN_MIN = 21'(SCAN_MIN_CYC);
    localparam logic [20:0] SCAN_MAX = 21'(SCAN_MAX_CYC);
    localparam logic [4:0] ITEM_LAST = 5'(`CCST_SCAN_ITEMS - 1);
    localparam logic [4:0] DIV_LAST = 5'(`CCST_HWCLK_DIV - 1);

    ccst_state_t st_reg;
    ccst_state_t st_next;
    logic wb_req;
    logic wb_wr;
    logic restart;
    logic scan_wrap;
    logic [31:0] rd_word;

    // Bus request decode; a request is taken while no answer is pending.
    assign wb_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign restart = wb_wr && (wb_adr_i == `CCST_REG_CTRL) && wb_dat_i[`CCST_CTRL_RESTART]
                     && !st_reg.frozen;
    assign scan_wrap = st_reg.scan_item == ITEM_LAST;

    // Register read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_word = '0;
        unique case (wb_adr_i)
            `CCST_REG_CTRL: rd_word[`CCST_CTRL_REV] = st_reg.rev_new;
            `CCST_REG_STAT: begin
                rd_word[`CCST_ST_ONESHOT] = st_reg.oneshot;
                rd_word[`CCST_ST_FAULT] = st_reg.scan_fault;
                rd_word[`CCST_ST_PRESET] = st_reg.proc_reset;
                rd_word[`CCST_ST_KERNEL] = st_reg.kernel;
                rd_word[`CCST_ST_TESTIRQ] = st_reg.test_irq;
                rd_word[`CCST_ST_FROZEN] = st_reg.frozen;
                rd_word[`CCST_ST_ITEM_LO +: 5] = st_reg.scan_item;
            end
            `CCST_REG_CFGRAW: rd_word[7:0] = st_reg.cfg_s2;
            `CCST_REG_DECODE: rd_word[`CCST_DEC_VALID:0] = st_reg.cfg;
            `CCST_REG_SCANPER: rd_word[20:0] = st_reg.scan_period;
            default: rd_word = '0;
        endcase
    end

    // Decodes the configuration bank for the selected revision.
    function automatic ccst_cfg_t decode_cfg(input logic [7:0] sw, input logic rev_new);
        ccst_cfg_t c;
        logic [2:0] grp;
        c = '0;
        c.valid = 1'b1;
        grp = {sw[`CCST_CFG_C4], sw[`CCST_CFG_C5], sw[`CCST_CFG_C6]};
        if (!rev_new) begin
            // Older revision: contact two standard/option, contact one A versus B.
            c.variant = sw[`CCST_CFG_C1] ? CCST_VAR_B : CCST_VAR_A;
            c.option = sw[`CCST_CFG_C2];
            c.term = CCST_TERM_STD;
        end else if (sw[`CCST_CFG_C2] && sw[`CCST_CFG_C3]) begin
            c.variant = CCST_VAR_C;
            c.valid = grp[1];
            unique case ({grp[2], grp[0]})
                2'h0: c.term = CCST_TERM_BR600;
                2'h1: c.term = CCST_TERM_BR150;
                2'h2: c.term = CCST_TERM_BR900;
                default: c.term = CCST_TERM_BR135;
            endcase
            c.slow = sw[`CCST_CFG_C7];
        end else begin
            c.variant = sw[`CCST_CFG_C1] ? CCST_VAR_B : CCST_VAR_A;
            c.option = sw[`CCST_CFG_C2];
            c.term = grp[0] ? CCST_TERM_ALT : CCST_TERM_STD;
            // Bad codes only mark the setting invalid; nothing else stops.
            c.valid = !sw[`CCST_CFG_C3] && !grp[1] && (grp[2] == sw[`CCST_CFG_C1]);
            c.slow = sw[`CCST_CFG_C7];
        end
        c.db_ref_775 = c.slow;
        return c;
    endfunction

    // Next-state logic for the whole block.
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        st_next.hw_tick = 1'b0;
        // Switch pins pass two flip-flops before use; they reset to the open level.
        // That keeps a fresh reset from looking like a closed contact or a false edge.
        st_next.svc_s1 = svc_sw_i;
        st_next.svc_s2 = st_reg.svc_s1;
        st_next.cfg_s1 = cfg_sw_i;
        st_next.cfg_s2 = st_reg.cfg_s1;
        // Processor clock enable, divided to stay below 3.9 MHz.
        // Rounding the divisor up keeps the rate under the limit and well off 4 MHz.
        if (st_reg.hw_div == DIV_LAST) begin
            st_next.hw_div = '0;
            st_next.hw_tick = 1'b1;
        end else begin
            st_next.hw_div = st_reg.hw_div + 5'h01;
        end
        // Service switches: reset hold, test interrupt, kernel test.
        st_next.proc_reset = !st_reg.svc_s2[`CCST_SVC_RESET];
        st_next.kernel = !st_reg.svc_s2[`CCST_SVC_KERNEL];
        st_next.test_prev = st_reg.svc_s2[`CCST_SVC_TEST];
        // The power-up kernel capture waits until the second stage holds the pin.
        // Until then the last test level is held open, so a test contact already closed counts as an edge.
        if (st_reg.por_cnt != `CCST_POR_WAIT) begin
            st_next.por_cnt = st_reg.por_cnt + 2'h1;
            st_next.test_prev = 1'b1;
            if (st_next.por_cnt == `CCST_POR_WAIT) begin
                st_next.kernel_por = !st_reg.svc_s2[`CCST_SVC_KERNEL];
            end
        end
        st_next.frozen = st_next.proc_reset || st_reg.kernel_por;
        if (wb_wr && (wb_adr_i == `CCST_REG_STAT) && wb_dat_i[`CCST_ST_TESTIRQ]) begin
            st_next.test_irq = 1'b0;
        end
        if (st_reg.test_prev && !st_reg.svc_s2[`CCST_SVC_TEST]) begin
            st_next.test_irq = 1'b1;
        end
        // Configuration decode and revision select.
        if (wb_wr && (wb_adr_i == `CCST_REG_CTRL)) begin
            st_next.rev_new = wb_dat_i[`CCST_CTRL_REV];
        end
        st_next.cfg = decode_cfg(st_reg.cfg_s2, st_reg.rev_new);
        // Retriggerable one-shot; a restart reloads the full width.
        unique case (st_reg.os_state)
            CCST_OS_IDLE: begin
                st_next.oneshot = 1'b0;
            end
            CCST_OS_PULSE: begin
                if (st_reg.os_cnt == '0) begin
                    st_next.os_state = CCST_OS_IDLE;
                    st_next.oneshot = 1'b0;
                end else begin
                    st_next.os_cnt = st_reg.os_cnt - 17'h00001;
                end
            end
        endcase
        if (restart) begin
            st_next.os_state = CCST_OS_PULSE;
            st_next.os_cnt = OS_LOAD;
            st_next.oneshot = 1'b1;
            st_next.tick = 1'b1;
            st_next.scan_item = scan_wrap ? 5'h00 : st_reg.scan_item + 5'h01;
        end
        // A held processor reset clears the pulse so no stale interval survives it.
        if (st_next.proc_reset) begin
            st_next.os_state = CCST_OS_IDLE;
            st_next.oneshot = 1'b0;
        end
        // Full scan period measurement and fault window.
        if (st_reg.scan_cnt != SCAN_MAX + 21'h000001) begin
            st_next.scan_cnt = st_reg.scan_cnt + 21'h000001;
        end else begin
            st_next.scan_fault = 1'b1;
        end
        // At each wrap the elapsed count is kept and judged against the window.
        if (restart && scan_wrap) begin
            st_next.scan_period = st_reg.scan_cnt;
            st_next.scan_cnt = 21'h000001;
            st_next.scan_fault = (st_reg.scan_cnt < SCAN_MIN) || (st_reg.scan_cnt > SCAN_MAX);
        end
        // Bus answer one cycle after the request.
        st_next.ack = wb_req;
        st_next.dat = wb_req ? rd_word : '0;
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg <= CCST_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign wb_dat_o = st_reg.dat;
    assign wb_ack_o = st_reg.ack;
    assign oneshot_o = st_reg.oneshot;
    assign tick_o = st_reg.tick;
    assign scan_item_o = st_reg.scan_item;
    assign timer_fault_o = st_reg.scan_fault;
    assign hw_tick_o = st_reg.hw_tick;
    assign proc_reset_o = st_reg.proc_reset;
    assign test_irq_o = st_reg.test_irq;
    assign kernel_test_o = st_reg.kernel;
    assign frozen_o = st_reg.frozen;
    assign cfg_o = st_reg.cfg;

    // Checks of the block's behaviour.
    localparam int HW_DIV_I = `CCST_HWCLK_DIV;
    logic [16:0] hi_len;

    // Counts cycles of the current pulse for the width check.
    // A tick restarts the count, so a retrigger measures the new interval.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || tick_o) begin
            hi_len <= 17'h00001;
        end else if (oneshot_o) begin
            hi_len <= hi_len + 17'h00001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Tick, one-shot, scan, processor clock, service contact, decode and bus checks.
    pulse_width_a: assert property ($fell(oneshot_o) && !proc_reset_o |-> hi_len == 17'(ONESHOT_CYC))
        else $error("one-shot pulse width wrong");
    restart_tick_a: assert property (restart && !st_next.proc_reset |=> tick_o && oneshot_o)
        else $error("restart did not start a pulse");
    scan_step_a: assert property (tick_o |-> scan_item_o == ($past(scan_item_o) == ITEM_LAST ? 5'h00
            : $past(scan_item_o) + 5'h01))
        else $error("scan item did not step");
    scan_hold_a: assert property (!tick_o |-> $stable(scan_item_o))
        else $error("scan item moved without a tick");
    scan_fault_a: assert property (restart && scan_wrap && st_reg.scan_cnt > SCAN_MAX |=> timer_fault_o)
        else $error("slow scan not flagged");
    hw_clock_a: assert property (hw_tick_o |-> ##HW_DIV_I hw_tick_o)
        else $error("hardware clock period wrong");
    reset_hold_a: assert property (!st_reg.svc_s2[`CCST_SVC_RESET] |=> proc_reset_o && frozen_o ##1 !oneshot_o)
        else $error("processor not held in reset");
    test_irq_a: assert property ($fell(st_reg.svc_s2[`CCST_SVC_TEST]) && st_reg.test_prev |=> ##1 test_irq_o)
        else $error("test interrupt not raised");
    frozen_tick_a: assert property (frozen_o |=> !tick_o)
        else $error("tick while frozen");
    slow_ref_a: assert property (cfg_o.slow |-> cfg_o.db_ref_775)
        else $error("slow mode without reference");
    variant_c_a: assert property (st_reg.rev_new && st_reg.cfg_s2[`CCST_CFG_C2] && st_reg.cfg_s2[`CCST_CFG_C3]
            |=> cfg_o.variant == CCST_VAR_C)
        else $error("variant C not decoded");
    wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");

    // Service contacts, configuration decode and scan item range.
    proc_idle_a: assert property (proc_reset_o |-> !oneshot_o)
        else $error("pulse while processor held");
    kernel_hold_a: assert property (st_reg.kernel_por |=> frozen_o)
        else $error("kernel test did not freeze");
    old_decode_a: assert property (!st_reg.rev_new |=> !cfg_o.slow && cfg_o.term == CCST_TERM_STD)
        else $error("older revision decode wrong");
    new_slow_a: assert property (st_reg.rev_new |=> cfg_o.slow == $past(st_reg.cfg_s2[`CCST_CFG_C7]))
        else $error("autorange speed not decoded");
    scan_range_a: assert property (scan_item_o <= ITEM_LAST)
        else $error("scan item out of range");

    // Main scenarios that the bench should reach.
    full_scan_c: cover property (tick_o && scan_item_o == 5'h00);
    retrigger_c: cover property (oneshot_o && restart);
    test_irq_c: cover property ($rose(test_irq_o));
    fault_c: cover property ($rose(timer_fault_o));
    freeze_c: cover property ($rose(frozen_o));
endmodule
`default_nettype wire

// ===== common/ccst_cfg.svh
`ifndef CCST_CFG_SVH
`define CCST_CFG_SVH
// Clock and derived timing.
`define CCST_CLK_HZ 100000000
`define CCST_ONESHOT_NS 500000
`define CCST_ONESHOT_CYC ((`CCST_ONESHOT_NS * (`CCST_CLK_HZ / 1000000)) / 1000)
`define CCST_HWCLK_HZ 3800000
`define CCST_HWCLK_DIV ((`CCST_CLK_HZ + `CCST_HWCLK_HZ - 1) / `CCST_HWCLK_HZ)
`define CCST_SCAN_MIN_HZ 90
`define CCST_SCAN_MAX_HZ 110
`define CCST_SCAN_MIN_CYC ((`CCST_CLK_HZ + `CCST_SCAN_MAX_HZ - 1) / `CCST_SCAN_MAX_HZ)
`define CCST_SCAN_MAX_CYC (`CCST_CLK_HZ / `CCST_SCAN_MIN_HZ)
`define CCST_SCAN_ITEMS 19
`define CCST_POR_WAIT 2'h3
// Counter widths.
`define CCST_OS_W 17
`define CCST_SCAN_W 21
`define CCST_DIV_W 5
// Register byte offsets.
`define CCST_REG_CTRL 8'h00
`define CCST_REG_STAT 8'h04
`define CCST_REG_CFGRAW 8'h08
`define CCST_REG_DECODE 8'h0C
`define CCST_REG_SCANPER 8'h10
// Control bits.
`define CCST_CTRL_RESTART 0
`define CCST_CTRL_REV 1
// Status bits.
`define CCST_ST_ONESHOT 0
`define CCST_ST_FAULT 1
`define CCST_ST_PRESET 2
`define CCST_ST_KERNEL 3
`define CCST_ST_TESTIRQ 4
`define CCST_ST_FROZEN 5
`define CCST_ST_ITEM_LO 8
// Decode register bits.
`define CCST_DEC_VALID 9
// Switch contacts, contact n on bit n-1; closed reads 0.
`define CCST_SVC_RESET 0
`define CCST_SVC_TEST 3
`define CCST_SVC_KERNEL 4
`define CCST_CFG_C1 0
`define CCST_CFG_C2 1
`define CCST_CFG_C3 2
`define CCST_CFG_C4 3
`define CCST_CFG_C5 4
`define CCST_CFG_C6 5
`define CCST_CFG_C7 6
`endif

// ===== common/ccst_pkg.sv
`default_nettype none
package ccst_pkg;
    typedef enum logic [1:0] {CCST_OS_IDLE = 2'h1, CCST_OS_PULSE = 2'h2} ccst_os_state_t;
    typedef enum logic [1:0] {CCST_VAR_A = 2'h0, CCST_VAR_B = 2'h1, CCST_VAR_C = 2'h2} ccst_variant_t;
    typedef enum logic [2:0] {
        CCST_TERM_STD = 3'h0,
        CCST_TERM_ALT = 3'h1,
        CCST_TERM_BR600 = 3'h2,
        CCST_TERM_BR150 = 3'h3,
        CCST_TERM_BR900 = 3'h4,
        CCST_TERM_BR135 = 3'h5
    } ccst_term_t;
    // Decoded configuration as handed to the processor.
    typedef struct packed {
        logic valid;
        logic db_ref_775;
        logic slow;
        ccst_term_t term;
        logic option;
        ccst_variant_t variant;
    } ccst_cfg_t;
    // Whole state of the block.
    typedef struct packed {
        ccst_os_state_t os_state;
        logic [16:0] os_cnt;
        logic oneshot;
        logic tick;
        logic [4:0] scan_item;
        logic [20:0] scan_cnt;
        logic [20:0] scan_period;
        logic scan_fault;
        logic [4:0] svc_s1;
        logic [4:0] svc_s2;
        logic [7:0] cfg_s1;
        logic [7:0] cfg_s2;
        logic [1:0] por_cnt;
        logic kernel_por;
        logic frozen;
        logic proc_reset;
        logic kernel;
        logic test_prev;
        logic test_irq;
        logic rev_new;
        ccst_cfg_t cfg;
        logic [4:0] hw_div;
        logic hw_tick;
        logic ack;
        logic [31:0] dat;
    } ccst_state_t;
    // Switch synchronisers start at the open level of their pull-ups.
    localparam ccst_state_t CCST_STATE_RST = '{os_state: CCST_OS_IDLE, svc_s1: 5'h1F, svc_s2: 5'h1F,
        cfg_s1: 8'hFF, cfg_s2: 8'hFF, cfg: '0, default: '0};
endpackage
`default_nettype wire

// ===== testbench/ccst_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// Models both switch banks; a closed contact pulls its line low.
module ccst_sw_model (
    input wire logic clk_i,
    input wire logic [4:0] svc_closed_i,
    input wire logic [7:0] cfg_closed_i,
    output logic [4:0] svc_sw_o,
    output logic [7:0] cfg_sw_o
);
    // Contacts settle one clock after the bench flips them.
    always_ff @(posedge clk_i) begin
        svc_sw_o <= ~svc_closed_i;
        cfg_sw_o <= ~cfg_closed_i;
    end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import ccst_pkg::*; ;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, oneshot_o, tick_o, timer_fault_o, hw_tick_o, proc_reset_o, test_irq_o, kernel_test_o, frozen_o;
    logic [4:0] scan_item_o, svc_sw, svc_cl = 5'h00;
    logic [7:0] cfg_sw, cfg_cl = 8'h00, lv;
    ccst_cfg_t cfg_o, ec, mc;
    logic [31:0] checks = 32'h0, n_fail = 32'h0, os_run = 32'h0, os_w = 32'h0, hw_cnt = 32'h0, hw_p = 32'h0;
    logic [31:0] n_tick = 32'h0, n0, cyc_n = 32'h0, rs = 32'hE2469BC0, r, me, mm;
    logic [31:0] q_exp[$];
    logic [31:0] q_msk[$];
    logic rev = 1'b0;

    // Device under test with shortened one-shot and scan-window counts.
    ccst_top #(.ONESHOT_CYC(20), .SCAN_MIN_CYC(300), .SCAN_MAX_CYC(500)) u_ccst_top (
        .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .svc_sw_i(svc_sw), .cfg_sw_i(cfg_sw), .oneshot_o(oneshot_o), .tick_o(tick_o), .scan_item_o(scan_item_o),
        .timer_fault_o(timer_fault_o), .hw_tick_o(hw_tick_o), .proc_reset_o(proc_reset_o), .test_irq_o(test_irq_o),
        .kernel_test_o(kernel_test_o), .frozen_o(frozen_o), .cfg_o(cfg_o));

    // Far-side switch banks.
    ccst_sw_model u_ccst_sw_model (.clk_i(clk_i), .svc_closed_i(svc_cl), .cfg_closed_i(cfg_cl),
        .svc_sw_o(svc_sw), .cfg_sw_o(cfg_sw));

    // Clock of 100 MHz.
    always #5 clk_i = ~clk_i;

    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 32'h0 && checks != 32'h0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 32'h1;
        if (seen !== exp) begin
            n_fail = n_fail + 32'h1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // Expected decode for the newer revision; c holds contact levels, open reads 1.
    function automatic ccst_cfg_t exp_cfg(input logic [7:0] c);
        ccst_cfg_t e;
        e = '0;
        e.slow = c[6];
        e.db_ref_775 = c[6];
        if (c[1] && c[2]) begin
            e.variant = CCST_VAR_C;
            e.term = ccst_term_t'(3'h2 + {1'b0, c[3], c[5]});
            e.valid = c[4];
        end else begin
            e.variant = c[0] ? CCST_VAR_B : CCST_VAR_A;
            e.option = c[1];
            e.term = c[5] ? CCST_TERM_ALT : CCST_TERM_STD;
            e.valid = !c[2] && !c[4] && (c[3] == c[0]);
        end
        return e;
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic bus cycle, held until ack is sampled, then a cycle idle.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q_exp.push_back(e);
        q_msk.push_back(m);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic restart();
        wb(1'b1, 8'h00, {30'h0, rev, 1'b1});
    endtask

    task automatic pace(input int n, input int gap);
        repeat (n) begin
            restart();
            wt(gap - 3);
        end
    endtask

    task automatic do_reset();
        resetn_i <= 1'b0;
        wt(20);
        resetn_i <= 1'b1;
        wt(6);
    endtask

    // Read answers are matched against the oldest queued expectation.
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we == 1'b0 && q_exp.size() != 0) begin
            me = q_exp.pop_front();
            mm = q_msk.pop_front();
            check(wb_dat_o & mm, me & mm);
        end
    end

    // Measures pulse width, hardware tick spacing and tick count; cuts a hang short.
    always @(posedge clk_i) begin
        os_run <= (oneshot_o === 1'b1) ? os_run + 32'h1 : 32'h0;
        if (oneshot_o !== 1'b1 && os_run != 32'h0) os_w <= os_run;
        hw_cnt <= (hw_tick_o === 1'b1) ? 32'h0 : hw_cnt + 32'h1;
        if (hw_tick_o === 1'b1) hw_p <= hw_cnt + 32'h1;
        if (tick_o === 1'b1) n_tick <= n_tick + 32'h1;
        cyc_n <= cyc_n + 32'h1;
        if (cyc_n == 32'h2710) begin
            n_fail = n_fail + 32'h1;
            give_verdict();
        end
    end

    // Main sequence.
    initial begin
        do_reset();
        rd(8'h04, 32'h0, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        pace(19, 25);
        wt(520);
        check(timer_fault_o, 32'h1);
        pace(19, 25);
        pace(19, 25);
        check(scan_item_o, 32'h0);
        check(timer_fault_o, 32'h0);
        rd(8'h10, 32'h1DB, 32'h1FFFFF);
        pace(18, 12);
        check(scan_item_o, 32'h12);
        pace(1, 12);
        check(timer_fault_o, 32'h1);
        // Let the running pulse end so the next width is measured alone.
        wt(20);
        n0 = n_tick;
        restart();
        wt(25);
        check(os_w, 32'h14);
        check(n_tick - n0, 32'h1);
        restart();
        restart();
        wt(30);
        check(os_w, 32'h17);
        check(hw_p >= 32'h1A && hw_p <= 32'h21, 32'h1);
        rev = 1'b1;
        wb(1'b1, 8'h00, 32'h2);
        rd(8'h00, 32'h2, 32'hFFFFFFFF);
        for (int i = 0; i < 128; i++) begin
            r = rnd();
            lv = {r[0], i[6:0]};
            cfg_cl <= ~lv;
            wt(6);
            ec = exp_cfg(lv);
            mc = '1;
            if (ec.variant == CCST_VAR_C) mc.option = 1'b0;
            check(32'(cfg_o) & 32'(mc), 32'(ec) & 32'(mc));
        end
        rd(8'h08, {24'h0, lv}, 32'hFFFFFFFF);
        rd(8'h0C, 32'(ec), {22'h3FFFFF, mc});
        rev = 1'b0;
        wb(1'b1, 8'h00, 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            lv = {r[7:2], i[1:0]};
            cfg_cl <= ~lv;
            wt(6);
            ec = '0;
            ec.variant = lv[0] ? CCST_VAR_B : CCST_VAR_A;
            ec.option = lv[1];
            mc = '0;
            mc.option = 1'b1;
            mc.variant = ccst_variant_t'(2'h3);
            check(32'(cfg_o) & 32'(mc), 32'(ec) & 32'(mc));
        end
        svc_cl <= 5'h01;
        wt(6);
        check({proc_reset_o, frozen_o}, 32'h3);
        restart();
        wt(2);
        check(oneshot_o, 32'h0);
        svc_cl <= 5'h00;
        wt(6);
        check({proc_reset_o, frozen_o}, 32'h0);
        svc_cl <= 5'h08;
        wt(6);
        svc_cl <= 5'h00;
        wt(6);
        check(test_irq_o, 32'h1);
        rd(8'h04, 32'h10, 32'h10);
        wb(1'b1, 8'h04, 32'h10);
        wt(2);
        check(test_irq_o, 32'h0);
        svc_cl <= 5'h10;
        do_reset();
        check({kernel_test_o, frozen_o}, 32'h3);
        svc_cl <= 5'h00;
        do_reset();
        check(frozen_o, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
